// *** adc_spi_pkg.sv ***
// Shared constants, command codes and helpers for both link ends
package adc_spi_pkg;
  localparam int WORD_W = 24;
  localparam int FRAME_WORDS = 3;
  localparam int REG_COUNT = 8;
  localparam int REG_AW = 3;
  localparam logic [15:0] CMD_NULL = 16'h0000;
  localparam logic [15:0] CMD_RESET = 16'h0011;
  localparam logic [15:0] CMD_STANDBY = 16'h0022;
  localparam logic [15:0] CMD_CONVERSION_RESUME_COMMAND = 16'h0033;
  localparam logic [15:0] CMD_LOCK = 16'h0555;
  localparam logic [15:0] CMD_UNLOCK = 16'h0655;
  localparam logic [15:0] RESP_RESET_OK = 16'hff23;
  localparam logic [15:0] RESP_RESET_CUT = 16'h0011;
  localparam logic [2:0] PFX_REGISTER_READ_COMMAND = 3'h5;
  localparam logic [2:0] PFX_REGISTER_WRITE_COMMAND = 3'h3;
  localparam logic [2:0] PFX_WACK = 3'h2;
  localparam logic [2:0] PFX_RHDR = 3'h7;
  localparam logic [5:0] ADDR_STATUS = 6'h00;
  localparam logic [5:0] ADDR_MODE = 6'h01;
  localparam logic [5:0] ADDR_SUPPLY = 6'h02;
  localparam int STAT_LOCK_BIT = 15;
  localparam int STAT_STBY_BIT = 14;
  localparam int STAT_CRCERR_BIT = 12;
  localparam int MODE_RXCRC_BIT = 0;
  localparam int SUPPLY_EN_BIT = 0;
  localparam logic [15:0] MODE_RST = 16'h0000;
  localparam logic [15:0] SUPPLY_RST = 16'h0001;
  localparam logic [15:0] CRC_SEED = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [23:0] CODE_MAX = 24'h7fffff;
  localparam logic [23:0] CODE_MIN = 24'h800000;
  localparam int SYS_PERIOD_NS = 50;
  localparam int GAP_CYCLES = 16;

  function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic b);
    crc_step = {crc[14:0], 1'b0} ^ ((crc[15] ^ b) ? CRC_POLY : 16'h0000);
  endfunction : crc_step
endpackage : adc_spi_pkg

// *** adc_spi_if.sv ***
// Four-wire serial link between host controller and converter end
`timescale 1ns/10ps
`default_nettype none
interface adc_spi_if;
  logic sclk;
  logic cs_n;
  logic din;
  logic dout;
  modport controller (output sclk, output cs_n, output din, input dout);
  modport target (input sclk, input cs_n, input din, output dout);
endinterface : adc_spi_if
`default_nettype wire

// *** adc_spi_device.sv ***
// Converter end: command decoder, register file and output framing on the link clock
//
// Contract
// RULE1 - Full-scale inputs give 7fffff or 800000
// RULE2 - Out-of-range results saturate, never wrap
// RULE3 - Results are two's complement
// RULE4 - Frame: response, data word, crc word
// RULE5 - Response goes out in following frame
// RULE6 - Null changes nothing, answers status
// RULE7 - Unknown words act as null
// RULE8 - Reset latched at frame end, defaults
// RULE9 - Reset answers ff23; cut frame 0011
// RULE10 - Host waits acquisition delay after reset
// RULE11 - Standby at frame end, echoed
// RULE12 - Host clears supply enable before standby
// RULE13 - Conversion_resume_command leaves standby, echoed
// RULE14 - Host sets supply enable after conversion_resume_command
// RULE15 - Lock: only null, read, unlock act
// RULE16 - Conversion data continues while locked
// RULE17 - Unlock clears lock, echoed
// RULE18 - Read decodes prefix, address, count
// RULE19 - Single read returns register as response
// RULE20 - Multi read: header then ascending registers
// RULE21 - Multi read frame omits conversion data
// RULE22 - Write answers 010, address, written-1
// RULE23 - Crc failure: only writes act, flag
// RULE24 - Locked other commands answer status
`timescale 1ns/10ps
`default_nettype none
module adc_spi_device #(
  parameter int RAW_W = 26
) (
  input wire logic reset,
  adc_spi_if.target link,
  input wire logic [RAW_W-1:0] raw_sample,
  output logic standby,
  output logic locked,
  output logic supply_en
);
  import adc_spi_pkg::*;

  typedef struct packed {
    logic rs1;
    logic rs2;
    logic [RAW_W-1:0] s1;
    logic [RAW_W-1:0] s2;
    logic [4:0] bit_cnt;
    logic [7:0] word_cnt;
    logic [23:0] in_sh;
    logic [15:0] cmd;
    logic pending;
    logic [23:0] out_sh;
    logic [15:0] resp;
    logic resp_status;
    logic multi;
    logic [5:0] r_addr;
    logic [6:0] r_cnt;
    logic [15:0] crc_in;
    logic [15:0] crc_out;
    logic crc_ok;
    logic [5:0] w_addr;
    logic [7:0] w_left;
    logic [6:0] w_done;
    logic locked;
    logic stby;
    logic crc_err;
    logic [REG_COUNT-1:0][15:0] regs;
  } dev_state_t;

  localparam logic signed [RAW_W-1:0] HI = {{(RAW_W-24){CODE_MAX[23]}}, CODE_MAX};
  localparam logic signed [RAW_W-1:0] LO = {{(RAW_W-24){CODE_MIN[23]}}, CODE_MIN};

  dev_state_t r;
  dev_state_t n;

  function automatic logic [15:0] status_word(input dev_state_t s);
    logic [15:0] v;
    v = 16'h0000;
    v[STAT_LOCK_BIT] = s.locked;
    v[STAT_STBY_BIT] = s.stby;
    v[STAT_CRCERR_BIT] = s.crc_err;
    return v;
  endfunction : status_word

  function automatic logic [15:0] reg_read(input dev_state_t s, input logic [5:0] a);
    if (a == ADDR_STATUS) begin
      return status_word(s);
    end else if (a < 6'(REG_COUNT)) begin
      return s.regs[a[REG_AW-1:0]];
    end
    return 16'h0000;
  endfunction : reg_read

  function automatic dev_state_t load_defaults(input dev_state_t s);
    dev_state_t t;
    t = s;
    t.regs = '0;
    t.regs[ADDR_MODE[REG_AW-1:0]] = MODE_RST;
    t.regs[ADDR_SUPPLY[REG_AW-1:0]] = SUPPLY_RST;
    t.locked = 1'b0;
    t.stby = 1'b0;
    t.crc_err = 1'b0;
    t.multi = 1'b0;
    return t;
  endfunction : load_defaults

  function automatic logic [23:0] clip(input logic [RAW_W-1:0] v);
    if ($signed(v) > HI) begin
      return CODE_MAX; // [RULE1] [RULE2]
    end else if ($signed(v) < LO) begin
      return CODE_MIN; // [RULE1] [RULE2]
    end
    return v[23:0]; // [RULE3]
  endfunction : clip

  always_comb begin
    logic [23:0] w;
    logic [15:0] cw;
    logic exec;
    logic cut;
    logic is_rd;
    logic [7:0] in_len;
    logic [7:0] out_len;
    logic [7:0] flen;
    logic [7:0] cpos;
    logic [7:0] idx;
    w = {r.in_sh[22:0], link.din};
    cw = (r.word_cnt == 8'h00) ? w[23:8] : r.cmd;
    exec = 1'b0;
    cut = 1'b0;
    is_rd = 1'b0;
    idx = r.word_cnt + 8'h01;
    n = r;
    n.rs1 = reset;
    n.rs2 = r.rs1;
    n.s1 = raw_sample;
    n.s2 = r.s1;
    out_len = r.multi ? 8'(r.r_cnt) + 8'h03 : 8'(FRAME_WORDS);
    in_len = (cw[15:13] == PFX_REGISTER_WRITE_COMMAND) ? 8'(cw[6:0]) + 8'h03 : 8'(FRAME_WORDS);
    flen = (in_len > out_len) ? in_len : out_len;
    cpos = (cw[15:13] == PFX_REGISTER_WRITE_COMMAND) ? in_len - 8'h01 : 8'h01;
    if (link.cs_n) begin
      if (r.pending) begin
        exec = 1'b1;
        cut = 1'b1;
      end
    end else begin
      n.in_sh = w;
      n.bit_cnt = r.bit_cnt + 5'h01;
      n.crc_out = crc_step(r.crc_out, r.out_sh[23]);
      n.out_sh = {r.out_sh[22:0], 1'b0};
      if (r.word_cnt == 8'h00 && r.bit_cnt == 5'h00 && r.resp_status) begin
        n.crc_err = 1'b0;
      end
      if (r.word_cnt < cpos) begin
        n.crc_in = crc_step(r.crc_in, link.din);
      end
      if (r.bit_cnt == 5'(WORD_W - 1)) begin
        n.bit_cnt = 5'h00;
        n.word_cnt = idx;
        if (r.word_cnt == 8'h00) begin
          n.cmd = cw;
          n.pending = 1'b1;
          n.w_addr = cw[12:7];
          n.w_done = 7'h00;
          n.w_left = 8'h00;
          if (cw[15:13] == PFX_REGISTER_WRITE_COMMAND && !r.locked) begin
            n.w_left = 8'(cw[6:0]) + 8'h01; // [RULE15]
          end
        end else if (r.w_left != 8'h00) begin
          if (r.w_addr != ADDR_STATUS && r.w_addr < 6'(REG_COUNT)) begin
            n.regs[r.w_addr[REG_AW-1:0]] = w[23:8];
            n.w_done = r.w_done + 7'h01;
          end
          n.w_addr = r.w_addr + 6'h01;
          n.w_left = r.w_left - 8'h01;
        end
        if (r.word_cnt == cpos && r.regs[ADDR_MODE[REG_AW-1:0]][MODE_RXCRC_BIT]) begin
          n.crc_ok = (w[23:8] == r.crc_in);
        end
        if (r.multi) begin
          if (idx <= 8'(r.r_cnt) + 8'h01) begin
            n.out_sh = {reg_read(r, 6'(8'(r.r_addr) + idx - 8'h01)), 8'h00}; // [RULE20]
          end else if (idx == 8'(r.r_cnt) + 8'h02) begin
            n.out_sh = {n.crc_out, 8'h00}; // [RULE21]
          end else begin
            n.out_sh = 24'h000000;
          end
        end else if (idx == 8'h01) begin
          n.out_sh = clip(r.s2); // [RULE4] [RULE16]
        end else if (idx == 8'h02) begin
          n.out_sh = {n.crc_out, 8'h00}; // [RULE4]
        end else begin
          n.out_sh = 24'h000000;
        end
        if (r.word_cnt == flen - 8'h01) begin
          exec = 1'b1;
        end
      end
    end
    if (exec) begin
      is_rd = (n.cmd[15:13] == PFX_REGISTER_READ_COMMAND);
      n.pending = 1'b0;
      n.multi = 1'b0;
      n.resp_status = 1'b0;
      if (cut && n.cmd == CMD_RESET) begin
        n.resp = RESP_RESET_CUT; // [RULE9]
      end else if (!n.crc_ok) begin
        n.crc_err = 1'b1; // [RULE23]
        n.resp_status = 1'b1;
      end else if (n.locked && !(n.cmd == CMD_NULL || is_rd || n.cmd == CMD_UNLOCK)) begin
        n.resp_status = 1'b1; // [RULE15] [RULE24]
      end else if (n.cmd == CMD_RESET) begin
        n = load_defaults(n); // [RULE8]
        n.resp = RESP_RESET_OK; // [RULE9]
      end else if (n.cmd == CMD_STANDBY) begin
        n.stby = 1'b1; // [RULE11]
        n.resp = n.cmd;
      end else if (n.cmd == CMD_CONVERSION_RESUME_COMMAND) begin
        n.stby = 1'b0; // [RULE13]
        n.resp = n.cmd;
      end else if (n.cmd == CMD_LOCK) begin
        n.locked = 1'b1; // [RULE15]
        n.resp = n.cmd;
      end else if (n.cmd == CMD_UNLOCK) begin
        n.locked = 1'b0; // [RULE17]
        n.resp = n.cmd;
      end else if (is_rd) begin
        n.r_addr = n.cmd[12:7]; // [RULE18]
        n.r_cnt = n.cmd[6:0];
        if (n.cmd[6:0] == 7'h00) begin
          n.resp = reg_read(n, n.cmd[12:7]); // [RULE19]
        end else begin
          n.multi = 1'b1; // [RULE21]
          n.resp = {PFX_RHDR, n.cmd[12:0]}; // [RULE20]
        end
      end else if (n.cmd[15:13] == PFX_REGISTER_WRITE_COMMAND) begin
        n.resp = {PFX_WACK, n.cmd[12:7], n.w_done - 7'h01}; // [RULE22]
      end else begin
        n.resp_status = 1'b1; // [RULE6] [RULE7]
      end
      if (n.resp_status) begin
        n.resp = status_word(n);
      end
    end
    if (link.cs_n) begin
      n.bit_cnt = 5'h00;
      n.word_cnt = 8'h00;
      n.w_left = 8'h00;
      n.crc_in = CRC_SEED;
      n.crc_out = CRC_SEED;
      n.crc_ok = 1'b1;
      n.out_sh = {n.resp, 8'h00}; // [RULE5]
    end
    if (r.rs2) begin
      n = load_defaults(n);
      n.pending = 1'b0;
      n.resp = 16'h0000;
      n.resp_status = 1'b0;
      n.bit_cnt = 5'h00;
      n.word_cnt = 8'h00;
      n.w_left = 8'h00;
      n.out_sh = 24'h000000;
    end
  end

  always_ff @(posedge link.sclk) begin
    r <= n;
  end

  assign link.dout = r.out_sh[23];
  assign standby = r.stby;
  assign locked = r.locked;
  assign supply_en = r.regs[ADDR_SUPPLY[REG_AW-1:0]][SUPPLY_EN_BIT];
endmodule : adc_spi_device
`default_nettype wire

// *** adc_spi_host.sv ***
// Host end: makes the link clock, sends command frames, returns received words
`timescale 1ns/10ps
`default_nettype none
module adc_spi_host #(
  parameter int SCLK_HALF = 4,
  parameter int REGACQ_NS = 5000
) (
  input wire logic sys_clk,
  input wire logic reset,
  adc_spi_if.controller link,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [15:0] req_cmd,
  input wire logic [7:0] req_words,
  input wire logic [15:0] wr_word,
  output logic wr_take,
  output logic [23:0] rx_word,
  output logic rx_valid
);
  import adc_spi_pkg::*;

  localparam int REGACQ_CYC = (REGACQ_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;

  typedef enum logic [2:0] {
    IDLE = 3'b001,
    FRAME = 3'b010,
    GAP = 3'b100
  } host_st_t;

  typedef struct packed {
    host_st_t st;
    logic [7:0] div;
    logic sclk;
    logic cs_n;
    logic [23:0] din_sh;
    logic [4:0] bit_cnt;
    logic [7:0] word_cnt;
    logic [7:0] len;
    logic [15:0] cmd;
    logic use_auto;
    logic [15:0] auto_val;
    logic [15:0] user_cmd;
    logic [7:0] user_len;
    logic then_main;
    logic then_post;
    logic [7:0] need;
    logic [15:0] gap;
    logic d1;
    logic d2;
    logic [23:0] rx_sh;
    logic ready;
    logic take;
    logic rvalid;
    logic [23:0] rword;
  } host_state_t;

  host_state_t r;
  host_state_t n;

  function automatic host_state_t start(input host_state_t s, input logic [15:0] c,
      input logic [7:0] l, input logic au, input logic [15:0] av);
    host_state_t t;
    logic [7:0] wl;
    t = s;
    wl = (c[15:13] == PFX_REGISTER_WRITE_COMMAND) ? 8'(c[6:0]) + 8'h03 : 8'(FRAME_WORDS);
    t.len = (l > wl) ? l : wl;
    t.len = (t.len > s.need) ? t.len : s.need; // [RULE21]
    t.need = (c[15:13] == PFX_REGISTER_READ_COMMAND && c[6:0] != 7'h00) ? 8'(c[6:0]) + 8'h03 : 8'(FRAME_WORDS);
    t.cmd = c;
    t.use_auto = au;
    t.auto_val = av;
    t.din_sh = {c, 8'h00};
    t.bit_cnt = 5'h00;
    t.word_cnt = 8'h00;
    t.st = FRAME;
    return t;
  endfunction : start

  always_comb begin
    logic tick;
    logic [15:0] wcmd;
    tick = (r.div == 8'(SCLK_HALF - 1));
    wcmd = {PFX_REGISTER_WRITE_COMMAND, ADDR_SUPPLY, 7'h00};
    n = r;
    n.d1 = link.dout;
    n.d2 = r.d1;
    n.take = 1'b0;
    n.rvalid = 1'b0;
    n.div = tick ? 8'h00 : r.div + 8'h01;
    if (tick) begin
      n.sclk = !r.sclk;
    end
    unique case (r.st)
      IDLE: begin
        if (req_valid && r.ready) begin
          n.ready = 1'b0;
          n.user_cmd = req_cmd;
          n.user_len = req_words;
          if (req_cmd == CMD_STANDBY) begin
            n = start(n, wcmd, 8'h00, 1'b1, 16'h0000); // [RULE12]
            n.then_main = 1'b1;
          end else begin
            n = start(n, req_cmd, req_words, 1'b0, 16'h0000);
            n.then_post = (req_cmd == CMD_CONVERSION_RESUME_COMMAND);
          end
        end
      end
      FRAME: begin
        if (tick && !r.sclk && !r.cs_n) begin
          n.rx_sh = {r.rx_sh[22:0], r.d2};
          n.bit_cnt = r.bit_cnt + 5'h01;
          if (r.bit_cnt == 5'(WORD_W - 1)) begin
            n.bit_cnt = 5'h00;
            n.word_cnt = r.word_cnt + 8'h01;
            n.rvalid = 1'b1; // [RULE4]
            n.rword = {r.rx_sh[22:0], r.d2};
          end
        end else if (tick && r.sclk) begin
          if (r.cs_n) begin
            n.cs_n = 1'b0;
          end else if (r.word_cnt == r.len) begin
            n.cs_n = 1'b1;
            n.st = GAP;
            n.gap = (r.cmd == CMD_RESET) ? 16'(REGACQ_CYC) : 16'(GAP_CYCLES); // [RULE10]
          end else if (r.bit_cnt == 5'h00) begin
            n.din_sh = 24'h000000;
            if (r.cmd[15:13] == PFX_REGISTER_WRITE_COMMAND && r.word_cnt <= 8'(r.cmd[6:0]) + 8'h01) begin
              n.din_sh = {r.use_auto ? r.auto_val : wr_word, 8'h00};
              n.take = !r.use_auto;
            end
          end else begin
            n.din_sh = {r.din_sh[22:0], 1'b0};
          end
        end
      end
      GAP: begin
        if (r.gap != 16'h0000) begin
          n.gap = r.gap - 16'h0001;
        end else if (r.then_main) begin
          n.then_main = 1'b0;
          n = start(n, r.user_cmd, r.user_len, 1'b0, 16'h0000);
        end else if (r.then_post) begin
          n.then_post = 1'b0;
          n = start(n, wcmd, 8'h00, 1'b1, 16'h0001); // [RULE14]
        end else begin
          n.st = IDLE;
          n.ready = 1'b1;
        end
      end
    endcase
    if (reset) begin
      n = '0;
      n.st = IDLE;
      n.cs_n = 1'b1;
      n.ready = 1'b1;
      n.need = 8'(FRAME_WORDS);
    end
  end

  always_ff @(posedge sys_clk) begin
    r <= n;
  end

  assign link.sclk = r.sclk;
  assign link.cs_n = r.cs_n;
  assign link.din = r.din_sh[23];
  assign req_ready = r.ready;
  assign wr_take = r.take;
  assign rx_word = r.rword;
  assign rx_valid = r.rvalid;
endmodule : adc_spi_host
`default_nettype wire

// *** adc_spi_checker.sv ***
// Frame-level checks on the serial link between host and converter ends
`timescale 1ns/10ps
`default_nettype none
module adc_spi_checker (
  input wire logic reset,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  input wire logic dout
);
  import adc_spi_pkg::*;
  logic [7:0] cnt_r;
  logic [15:0] dsh_r;
  logic [15:0] osh_r;
  logic [15:0] cmd_r;
  logic [15:0] pcmd_r;
  logic lk_r;
  logic lkb_r;
  logic at16;
  logic known;
  assign at16 = (cnt_r == 8'h10);
  assign known = (pcmd_r inside {CMD_NULL, CMD_RESET, CMD_STANDBY, CMD_CONVERSION_RESUME_COMMAND, CMD_LOCK,
    CMD_UNLOCK}) || (pcmd_r[15:13] == PFX_REGISTER_READ_COMMAND) || (pcmd_r[15:13] == PFX_REGISTER_WRITE_COMMAND);
  default clocking cb @(posedge sclk); endclocking
  default disable iff (reset);
  // Shift both lines, keep last command and lock state around it
  always_ff @(posedge sclk) begin
    if (reset) begin
      cnt_r <= 8'h00;
      cmd_r <= CMD_NULL;
      pcmd_r <= CMD_NULL;
      lk_r <= 1'b0;
      lkb_r <= 1'b0;
    end else if (!cs_n) begin
      cnt_r <= cnt_r + 8'h01;
      dsh_r <= {dsh_r[14:0], din};
      osh_r <= {osh_r[14:0], dout};
      if (cnt_r == 8'h0f) cmd_r <= {dsh_r[14:0], din};
    end else if (cnt_r != 8'h00) begin
      cnt_r <= 8'h00;
      pcmd_r <= cmd_r;
      lkb_r <= lk_r;
      lk_r <= lk_r ? (cmd_r != CMD_UNLOCK) : (cmd_r == CMD_LOCK);
    end
  end
  a_null_status: assert property (
    at16 && (pcmd_r == CMD_NULL || !known) |-> osh_r[15] == lk_r)
    else $error("status answer lock bit wrong");
  a_standby_echo: assert property (
    at16 && !lkb_r && pcmd_r == CMD_STANDBY |-> osh_r == CMD_STANDBY)
    else $error("standby not echoed");
  a_conversion_resume_command_echo: assert property (
    at16 && !lkb_r && pcmd_r == CMD_CONVERSION_RESUME_COMMAND |-> osh_r == CMD_CONVERSION_RESUME_COMMAND)
    else $error("conversion_resume_command not echoed");
  a_lock_echo: assert property (
    at16 && !lkb_r && pcmd_r == CMD_LOCK |-> osh_r == CMD_LOCK)
    else $error("lock not echoed");
  a_unlock_echo: assert property (
    at16 && lkb_r && pcmd_r == CMD_UNLOCK |-> osh_r == CMD_UNLOCK)
    else $error("unlock not echoed");
  a_reset_ack: assert property (
    at16 && !lkb_r && pcmd_r == CMD_RESET |-> osh_r == RESP_RESET_OK)
    else $error("reset answer wrong");
  a_read_header: assert property (
    at16 && pcmd_r[15:13] == PFX_REGISTER_READ_COMMAND && pcmd_r[6:0] != 7'h00
    |-> osh_r == {PFX_RHDR, pcmd_r[12:0]})
    else $error("multi read header wrong");
  a_write_ack: assert property (
    at16 && !lkb_r && pcmd_r[15:13] == PFX_REGISTER_WRITE_COMMAND
    |-> osh_r[15:7] == {PFX_WACK, pcmd_r[12:7]})
    else $error("write answer wrong");
  a_locked_refuse: assert property (
    at16 && lkb_r && pcmd_r != CMD_NULL && pcmd_r != CMD_UNLOCK
    && pcmd_r[15:13] != PFX_REGISTER_READ_COMMAND |-> osh_r[15] ##1 !cs_n)
    else $error("locked command not refused");
  a_whole_words: assert property (
    cs_n && cnt_r != 8'h00 |-> (cnt_r % 24) == 0 && cnt_r >= 8'h48)
    else $error("frame not whole words");
endmodule : adc_spi_checker
`default_nettype wire

// *** tb_top.sv ***
// Bench joining host and converter ends across the serial link
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import adc_spi_pkg::*;
  logic sys_clk = 1'b0;
  logic host_rst, dev_rst, req_valid, req_ready, wr_take, rx_valid, standby, locked, supply_en;
  logic [15:0] req_cmd, wr_word;
  logic [7:0] req_words;
  logic [23:0] rx_word;
  logic [25:0] raw_sample;
  logic [31:0] rnd;
  logic [23:0] rxq[$];
  logic [15:0] wq[$];
  logic [15:0] rv[5];
  logic [25:0] edge_v[9] = '{26'h1ffffff, 26'h07fffff, 26'h0800000, 26'h0000001, 26'h0000000,
    26'h3ffffff, 26'h3800000, 26'h37fffff, 26'h2000000};
  int failures = 0;
  int samples_checked = 0;
  adc_spi_if link_if();
  adc_spi_host #(.REGACQ_NS(500)) adc_spi_host_i (.sys_clk(sys_clk), .reset(host_rst),
    .link(link_if), .req_valid(req_valid), .req_ready(req_ready), .req_cmd(req_cmd),
    .req_words(req_words), .wr_word(wr_word), .wr_take(wr_take), .rx_word(rx_word),
    .rx_valid(rx_valid));
  adc_spi_device adc_spi_device_i (.reset(dev_rst), .link(link_if), .raw_sample(raw_sample),
    .standby(standby), .locked(locked), .supply_en(supply_en));
  adc_spi_checker adc_spi_checker_i (.reset(dev_rst), .sclk(link_if.sclk), .cs_n(link_if.cs_n),
    .din(link_if.din), .dout(link_if.dout));
  always #(SYS_PERIOD_NS / 2) sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (rx_valid) rxq.push_back(rx_word);
  always @(posedge sys_clk) begin
    if (wr_take) begin
      void'(wq.pop_front());
    end
    wr_word <= (wq.size() != 0) ? wq[0] : 16'h0000;
  end
  function automatic logic [23:0] w16(input logic [15:0] v);
    return {v, 8'h00};
  endfunction : w16
  function automatic logic [23:0] clip(input logic signed [25:0] v);
    if (v > 26'sh07fffff) return CODE_MAX;
    if (v < 26'sh3800000) return CODE_MIN;
    return v[23:0];
  endfunction : clip
  function automatic logic [23:0] crc_of(input logic [47:0] b);
    logic [15:0] c;
    c = CRC_SEED;
    for (int i = 47; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i]) ? CRC_POLY : 16'h0000);
    return {c, 8'h00};
  endfunction : crc_of
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic wait_ready();
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 30000) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 30000) begin
      failures++;
      $display("ERROR %0t: host never ready", $time);
      give_verdict();
    end
  endtask : wait_ready
  task automatic xfer(input logic [15:0] cmd, input logic [7:0] words);
    wait_ready();
    rxq.delete();
    req_cmd <= cmd;
    req_words <= words;
    req_valid <= 1'b1;
    @(posedge sys_clk);
    req_valid <= 1'b0;
    @(posedge sys_clk);
    wait_ready();
  endtask : xfer
  task automatic load(input logic [15:0] v);
    wq.push_back(v);
  endtask : load
  initial begin
    host_rst = 1'b1;
    dev_rst = 1'b1;
    req_valid = 1'b0;
    req_cmd = 16'h0000;
    req_words = 8'h03;
    raw_sample = 26'h0000000;
    void'($urandom(62));
    repeat (5) @(posedge sys_clk);
    host_rst <= 1'b0;
    // Device reset needs the link clock running
    repeat (60) @(posedge sys_clk);
    dev_rst <= 1'b0;
    repeat (40) @(posedge sys_clk);
    for (int i = 0; i < 13; i++) begin
      rnd = $urandom;
      raw_sample <= (i < 9) ? edge_v[i] : (i[0] ? rnd[25:0] : {{2{rnd[23]}}, rnd[23:0]});
      xfer((i == 3) ? 16'h1234 : CMD_NULL, 8'h03);
      xfer(CMD_NULL, 8'h03);
      chk(rxq[1], clip(raw_sample), "data word");
      chk(rxq[2], crc_of({rxq[0], rxq[1]}), "crc word");
      chk(24'(rxq.size()), 24'h000003, "frame size");
      chk({22'h0, rxq[0][23:22]}, 24'h0, "status");
    end
    $display("test conversion codes done");
    for (int k = 0; k < 5; k++) begin
      rv[k] = 16'($urandom);
      load(rv[k]);
    end
    xfer({PFX_REGISTER_WRITE_COMMAND, 6'h03, 7'h04}, 8'h07);
    xfer({PFX_REGISTER_READ_COMMAND, 6'h03, 7'h04}, 8'h03);
    chk(rxq[0], w16({PFX_WACK, 6'h03, 7'h04}), "write answer");
    xfer(CMD_NULL, 8'h07);
    chk(rxq[0], w16({PFX_RHDR, 6'h03, 7'h04}), "read header");
    for (int k = 0; k < 5; k++) chk(rxq[k + 1], w16(rv[k]), "read data");
    chk(24'(rxq.size()), 24'h000007, "read frame size");
    for (int k = 0; k < 4; k++) load(16'h00a5);
    xfer({PFX_REGISTER_WRITE_COMMAND, 6'h06, 7'h03}, 8'h06);
    xfer({PFX_REGISTER_READ_COMMAND, 6'h05, 7'h00}, 8'h03);
    chk(rxq[0], w16({PFX_WACK, 6'h06, 7'h01}), "partial write answer");
    load(16'hffff);
    xfer({PFX_REGISTER_WRITE_COMMAND, ADDR_STATUS, 7'h00}, 8'h03);
    chk(rxq[0], w16(rv[2]), "single read");
    xfer(CMD_NULL, 8'h03);
    chk(rxq[0], w16({PFX_WACK, ADDR_STATUS, 7'h7f}), "read-only write");
    $display("test register access done");
    xfer(CMD_LOCK, 8'h03);
    chk({23'h0, locked}, 24'h1, "locked");
    load(~rv[0]);
    rnd = $urandom;
    raw_sample <= {{2{rnd[23]}}, rnd[23:0]};
    xfer({PFX_REGISTER_WRITE_COMMAND, 6'h03, 7'h00}, 8'h03);
    chk(rxq[0], w16(CMD_LOCK), "lock echo");
    xfer(CMD_UNLOCK, 8'h03);
    chk({23'h0, rxq[0][23]}, 24'h1, "locked refusal");
    chk(rxq[1], clip(raw_sample), "locked data");
    xfer({PFX_REGISTER_READ_COMMAND, 6'h03, 7'h00}, 8'h03);
    chk(rxq[0], w16(CMD_UNLOCK), "unlock echo");
    xfer(CMD_NULL, 8'h03);
    chk(rxq[0], w16(rv[0]), "write kept out");
    chk({23'h0, locked}, 24'h0, "unlocked");
    $display("test lock done");
    xfer(CMD_STANDBY, 8'h03);
    chk(rxq[3], w16({PFX_WACK, ADDR_SUPPLY, 7'h00}), "supply off first");
    chk({22'h0, standby, supply_en}, 24'h2, "in standby");
    xfer(CMD_CONVERSION_RESUME_COMMAND, 8'h03);
    chk(rxq[0], w16(CMD_STANDBY), "standby echo");
    chk(rxq[3], w16(CMD_CONVERSION_RESUME_COMMAND), "conversion_resume_command echo");
    chk({22'h0, standby, supply_en}, 24'h1, "awake");
    $display("test standby done");
    load(16'h005a);
    xfer({PFX_REGISTER_WRITE_COMMAND, 6'h03, 7'h00}, 8'h03);
    xfer(CMD_RESET, 8'h03);
    xfer({PFX_REGISTER_READ_COMMAND, 6'h03, 7'h00}, 8'h03);
    chk(rxq[0], w16(RESP_RESET_OK), "reset answer");
    xfer({PFX_REGISTER_READ_COMMAND, ADDR_SUPPLY, 7'h00}, 8'h03);
    chk(rxq[0], 24'h000000, "reg default");
    xfer(CMD_NULL, 8'h03);
    chk(rxq[0], w16(SUPPLY_RST), "supply default");
    $display("test reset done");
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
